// ---- hw/status_event_pkg.sv ----
// Constants for the status event summary block: register selects, bit layouts, reset values.
// Assumes a single synchronous clock domain.
package status_event_pkg;
   localparam int REG_W         = 16;
   localparam int PHASE_N       = 3;
   localparam int PHASE_W       = 2;
   localparam int SEL_W         = 4;
   // Register selects for the query port
   localparam logic [3:0] SEL_RUN_EVENT     = 4'h0;
   localparam logic [3:0] SEL_RUN_LIVE      = 4'h1;
   localparam logic [3:0] SEL_RUN_MASK      = 4'h2;
   localparam logic [3:0] SEL_FAULT_EVENT   = 4'h3;
   localparam logic [3:0] SEL_FAULT_LIVE    = 4'h4;
   localparam logic [3:0] SEL_FAULT_MASK    = 4'h5;
   localparam logic [3:0] SEL_PHASE_EVENT   = 4'h6;
   localparam logic [3:0] SEL_PHASE_LIVE    = 4'h7;
   localparam logic [3:0] SEL_PHASE_MASK    = 4'h8;
   // Operation bit positions
   localparam int BIT_TRIM_DONE             = 0;
   localparam int BIT_STEP_SEQUENCE_DONE    = 3;
   localparam int BIT_ACQUISITION_DONE      = 4;
   // Questionable bit positions
   localparam int BIT_VOLTAGE_FAULT         = 0;
   localparam int BIT_OVERCURRENT_TRIP      = 1;
   localparam int BIT_THERMAL_TRIP          = 3;
   localparam int BIT_REMOTE_INHIBIT        = 9;
   localparam int BIT_CURRENT_LIMIT_ACTIVE  = 12;
   localparam logic [15:0] RUN_USED_MASK    = 16'h0019;
   localparam logic [15:0] FAULT_USED_MASK  = 16'h120B;
   localparam logic [15:0] MASK_RESET       = 16'h0000;
   localparam logic [15:0] EVENT_RESET      = 16'h0000;
   // Status byte position of the questionable summary
   localparam int STB_FAULT_BIT             = 3;
endpackage

// ---- hw/status_event_summary.sv ----
// Status event summary: operation, questionable and per-phase questionable register groups.
// Assumes condition sources are synchronous to clk; query port is one access per cycle.
//
// Overview of operation
// - Four status groups exist; standard event group is kept outside this block.
// - Operation, questionable and per-phase groups each have condition, mask, event.
// - Operation bit 0 reports trim cycle finished.
// - Operation bit 3 reports triggered transient sequence finished.
// - Operation bit 4 reports acquisition finished; other operation bits unused.
// - Operation event register is read-only and latches events until cleared.
// - Reading operation event returns contents, then clears all bits except those whose condition is live.
// - Operation condition register shows live unlatched source state.
// - Operation summary is OR of masked operation event bits.
// - Operation mask is read/write, resets to zero.
// - Questionable bit 0 reports voltage protection tripped.
// - Questionable bit 1 reports overcurrent protection tripped.
// - Questionable bit 3 reports over-temperature protection tripped.
// - Questionable bit 9 reports remote inhibit active.
// - Questionable bit 12 reports rms current limit; other bits unused.
// - Each phase has its own register set; access goes to the selected phase.
// - Reading questionable event returns contents, then clears all bits except those whose condition is live.
// - Questionable summary, status byte bit 3, is OR of masked events.
`timescale 1ns/1ns
`default_nettype none
module status_event_summary
   import status_event_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // Operation sources
   input  wire logic                trim_done,
   input  wire logic                step_sequence_done,
   input  wire logic                acquisition_done,
   // Questionable sources, one per phase
   input  wire logic [PHASE_N-1:0]  voltage_fault,
   input  wire logic [PHASE_N-1:0]  overcurrent_trip,
   input  wire logic [PHASE_N-1:0]  thermal_trip,
   input  wire logic [PHASE_N-1:0]  remote_inhibit,
   input  wire logic [PHASE_N-1:0]  current_limit_active,
   // Query port
   input  wire logic [PHASE_W-1:0]  phase_select,
   input  wire logic [SEL_W-1:0]    reg_select,
   input  wire logic                reg_read,
   input  wire logic                reg_write,
   input  wire logic [REG_W-1:0]    reg_wdata,
   output logic      [REG_W-1:0]    reg_rdata,
   output logic                     reg_rvalid,
   // Summary bits
   output logic                     run_summary,
   output logic                     fault_summary,
   output logic [7:0]               status_byte
);

   logic [REG_W-1:0] run_live_state;
   logic [REG_W-1:0] run_event_latch;
   logic [REG_W-1:0] run_event_mask;
   logic [REG_W-1:0] fault_live_state;
   logic [REG_W-1:0] fault_event_latch;
   logic [REG_W-1:0] fault_event_mask;
   logic [REG_W-1:0] phase_live    [PHASE_N];
   logic [REG_W-1:0] phase_event   [PHASE_N];
   logic [REG_W-1:0] phase_mask    [PHASE_N];
   logic [REG_W-1:0] run_cond_now;
   logic [REG_W-1:0] phase_cond_now [PHASE_N];
   logic [REG_W-1:0] fault_cond_now;
   logic [REG_W-1:0] next_rdata;
   logic             phase_ok;

   // Place per-phase questionable sources into the register layout
   function automatic logic [REG_W-1:0] fault_word(input logic vf, input logic oc, input logic ot,
                                                   input logic ri, input logic cl);
      logic [REG_W-1:0] w;
      w = '0;
      w[BIT_VOLTAGE_FAULT]        = vf;
      w[BIT_OVERCURRENT_TRIP]     = oc;
      w[BIT_THERMAL_TRIP]         = ot;
      w[BIT_REMOTE_INHIBIT]       = ri;
      w[BIT_CURRENT_LIMIT_ACTIVE] = cl;
      return w;
   endfunction

   // Latching event update: new events win over the clear
   function automatic logic [REG_W-1:0] event_next(input logic [REG_W-1:0] cur, input logic [REG_W-1:0] cond,
                                                   input logic clr, input logic [REG_W-1:0] used);
      return ((clr ? '0 : cur) | cond) & used;
   endfunction

   // Summary of the enabled event bits of one group
   function automatic logic masked_any(input logic [REG_W-1:0] ev, input logic [REG_W-1:0] en);
      return |(ev & en);
   endfunction

   // Status byte carries only the questionable summary
   function automatic logic [7:0] stb_word(input logic fault_on);
      logic [7:0] b;
      b = 8'h00;
      b[STB_FAULT_BIT] = fault_on;
      return b;
   endfunction

   always_comb
   begin
      run_cond_now = '0;
      run_cond_now[BIT_TRIM_DONE]          = trim_done;
      run_cond_now[BIT_STEP_SEQUENCE_DONE] = step_sequence_done;
      run_cond_now[BIT_ACQUISITION_DONE]   = acquisition_done;
      fault_cond_now = '0;
      for (int p = 0; p < PHASE_N; p++)
      begin
         phase_cond_now[p] = fault_word(voltage_fault[p], overcurrent_trip[p], thermal_trip[p],
                                        remote_inhibit[p], current_limit_active[p]);
         fault_cond_now    = fault_cond_now | phase_cond_now[p];
      end
   end

   assign phase_ok = (phase_select < PHASE_W'(PHASE_N));

   // Live condition registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         run_live_state   <= '0;
         fault_live_state <= '0;
         for (int p = 0; p < PHASE_N; p++)
            phase_live[p] <= '0;
      end
      else
      begin
         run_live_state   <= run_cond_now;
         fault_live_state <= fault_cond_now;
         for (int p = 0; p < PHASE_N; p++)
            phase_live[p] <= phase_cond_now[p];
      end
   end

   // Event latches with clear on read
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         run_event_latch   <= EVENT_RESET;
         fault_event_latch <= EVENT_RESET;
         for (int p = 0; p < PHASE_N; p++)
            phase_event[p] <= EVENT_RESET;
      end
      else
      begin
         run_event_latch   <= event_next(run_event_latch, run_live_state,
                                         reg_read && reg_select == SEL_RUN_EVENT, RUN_USED_MASK);
         fault_event_latch <= event_next(fault_event_latch, fault_live_state,
                                         reg_read && reg_select == SEL_FAULT_EVENT, FAULT_USED_MASK);
         for (int p = 0; p < PHASE_N; p++)
            phase_event[p] <= event_next(phase_event[p], phase_live[p],
                                         reg_read && reg_select == SEL_PHASE_EVENT &&
                                         phase_select == PHASE_W'(p), FAULT_USED_MASK);
      end
   end

   // Enable masks
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         run_event_mask   <= MASK_RESET;
         fault_event_mask <= MASK_RESET;
         for (int p = 0; p < PHASE_N; p++)
            phase_mask[p] <= MASK_RESET;
      end
      else if (reg_write)
      begin
         if (reg_select == SEL_RUN_MASK)
            run_event_mask <= reg_wdata & RUN_USED_MASK;
         if (reg_select == SEL_FAULT_MASK)
            fault_event_mask <= reg_wdata & FAULT_USED_MASK;
         for (int p = 0; p < PHASE_N; p++)
            if (reg_select == SEL_PHASE_MASK && phase_select == PHASE_W'(p))
               phase_mask[p] <= reg_wdata & FAULT_USED_MASK;
      end
   end

   // Read mux
   always_comb
   begin
      next_rdata = '0;
      case (reg_select)
         SEL_RUN_EVENT   : next_rdata = run_event_latch;
         SEL_RUN_LIVE    : next_rdata = run_live_state;
         SEL_RUN_MASK    : next_rdata = run_event_mask;
         SEL_FAULT_EVENT : next_rdata = fault_event_latch;
         SEL_FAULT_LIVE  : next_rdata = fault_live_state;
         SEL_FAULT_MASK  : next_rdata = fault_event_mask;
         SEL_PHASE_EVENT : next_rdata = phase_ok ? phase_event[phase_select] : '0;
         SEL_PHASE_LIVE  : next_rdata = phase_ok ? phase_live[phase_select] : '0;
         SEL_PHASE_MASK  : next_rdata = phase_ok ? phase_mask[phase_select] : '0;
         default         : next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_read;
         if (reg_read)
            reg_rdata <= next_rdata;
      end
   end

   // Summary bits from current latched events and masks
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         run_summary   <= 1'b0;
         fault_summary <= 1'b0;
         status_byte   <= 8'h00;
      end
      else
      begin
         run_summary   <= masked_any(run_event_latch, run_event_mask);
         fault_summary <= masked_any(fault_event_latch, fault_event_mask);
         status_byte   <= stb_word(masked_any(fault_event_latch, fault_event_mask));
      end
   end

   // Checks
   trim_latch_a: assert property (@(posedge clk) disable iff (srst)
      run_live_state[BIT_TRIM_DONE] |=> run_event_latch[BIT_TRIM_DONE])
      else $error("trim event not latched");
   event_hold_a: assert property (@(posedge clk) disable iff (srst)
      run_event_latch[BIT_ACQUISITION_DONE] && !(reg_read && reg_select == SEL_RUN_EVENT)
      |=> run_event_latch[BIT_ACQUISITION_DONE])
      else $error("operation event lost without read");
   read_clear_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_RUN_EVENT |=> run_event_latch == $past(run_live_state)
      && reg_rdata == $past(run_event_latch))
      else $error("operation event read did not clear");
   set_wins_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_FAULT_EVENT && fault_live_state[BIT_THERMAL_TRIP]
      |=> fault_event_latch[BIT_THERMAL_TRIP])
      else $error("event lost on clearing read");
   live_cond_a: assert property (@(posedge clk) disable iff (srst)
      ##1 run_live_state[BIT_STEP_SEQUENCE_DONE] == $past(step_sequence_done))
      else $error("operation condition not live");
   run_sum_a: assert property (@(posedge clk) disable iff (srst)
      ##1 run_summary == |($past(run_event_latch) & $past(run_event_mask)))
      else $error("operation summary wrong");
   fault_sum_a: assert property (@(posedge clk) disable iff (srst)
      ##1 status_byte[STB_FAULT_BIT] == |($past(fault_event_latch) & $past(fault_event_mask)))
      else $error("questionable summary wrong");
   unused_zero_a: assert property (@(posedge clk) disable iff (srst)
      ((run_event_latch | run_event_mask) & ~RUN_USED_MASK) == '0
      && ((fault_event_latch | fault_event_mask) & ~FAULT_USED_MASK) == '0)
      else $error("unused bit set");
   mask_write_a: assert property (@(posedge clk) disable iff (srst)
      reg_write && reg_select == SEL_RUN_MASK |=> run_event_mask == ($past(reg_wdata) & RUN_USED_MASK))
      else $error("operation mask write failed");
   inhibit_a: assert property (@(posedge clk) disable iff (srst)
      remote_inhibit[0] |=> ##1 fault_event_latch[BIT_REMOTE_INHIBIT])
      else $error("remote inhibit not latched");
   fault_clear_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_FAULT_EVENT |=> fault_event_latch == $past(fault_live_state)
      && reg_rdata == $past(fault_event_latch))
      else $error("questionable event read did not clear");
   phase_clear_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_PHASE_EVENT && phase_select == 2'h1
      |=> phase_event[1] == $past(phase_live[1]) && reg_rdata == $past(phase_event[1]))
      else $error("phase event read did not clear");
   rvalid_pulse_a: assert property (@(posedge clk) disable iff (srst)
      ##1 reg_rvalid == $past(reg_read))
      else $error("read answer not one cycle after request");
   rdata_hold_a: assert property (@(posedge clk) disable iff (srst)
      !reg_read |=> $stable(reg_rdata))
      else $error("read data changed without read");
   live_read_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_RUN_LIVE |=> reg_rdata == $past(run_live_state))
      else $error("operation condition read wrong");
   mask_read_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_RUN_MASK |=> reg_rdata == $past(run_event_mask))
      else $error("operation mask read wrong");
   fault_mask_a: assert property (@(posedge clk) disable iff (srst)
      reg_write && reg_select == SEL_FAULT_MASK |=> fault_event_mask == ($past(reg_wdata) & FAULT_USED_MASK))
      else $error("questionable mask write failed");
   mask_keep_a: assert property (@(posedge clk) disable iff (srst)
      reg_write && reg_select != SEL_RUN_MASK |=> $stable(run_event_mask))
      else $error("operation mask changed by other write");
   phase_mask_a: assert property (@(posedge clk) disable iff (srst)
      reg_write && reg_select == SEL_PHASE_MASK && phase_select == 2'h1 |=> phase_mask[1] == ($past(reg_wdata) & FAULT_USED_MASK))
      else $error("phase mask write failed");
   phase_isolate_a: assert property (@(posedge clk) disable iff (srst)
      reg_write && reg_select == SEL_PHASE_MASK && phase_select != 2'h0 |=> $stable(phase_mask[0]))
      else $error("phase mask written for other phase");
   bad_phase_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && phase_select == 2'h3 && reg_select >= SEL_PHASE_EVENT && reg_select <= SEL_PHASE_MASK |=> reg_rdata == '0)
      else $error("invalid phase read not zero");
   bad_sel_a: assert property (@(posedge clk) disable iff (srst)
      reg_read && reg_select > SEL_PHASE_MASK |=> reg_rdata == '0)
      else $error("unused select read not zero");
   stb_spare_a: assert property (@(posedge clk) disable iff (srst)
      fault_summary == status_byte[STB_FAULT_BIT] && (status_byte & ~(8'h01 << STB_FAULT_BIT)) == 8'h00)
      else $error("status byte layout wrong");
   fault_sum_lvl_a: assert property (@(posedge clk) disable iff (srst)
      ##1 fault_summary == |($past(fault_event_latch) & $past(fault_event_mask)))
      else $error("questionable summary level wrong");
   fault_hold_a: assert property (@(posedge clk) disable iff (srst)
      fault_event_latch[BIT_VOLTAGE_FAULT] && !(reg_read && reg_select == SEL_FAULT_EVENT) |=> fault_event_latch[BIT_VOLTAGE_FAULT])
      else $error("questionable event lost without read");
   phase_latch_a: assert property (@(posedge clk) disable iff (srst)
      phase_live[2][BIT_OVERCURRENT_TRIP] |=> phase_event[2][BIT_OVERCURRENT_TRIP])
      else $error("phase event not latched");
   fault_or_a: assert property (@(posedge clk) disable iff (srst)
      fault_live_state == (phase_live[0] | phase_live[1] | phase_live[2]))
      else $error("questionable condition not OR of phases");
   step_latch_a: assert property (@(posedge clk) disable iff (srst)
      run_live_state[BIT_STEP_SEQUENCE_DONE] |=> run_event_latch[BIT_STEP_SEQUENCE_DONE])
      else $error("sequence event not latched");
   trim_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 run_live_state[BIT_TRIM_DONE] == $past(trim_done))
      else $error("trim condition wrong");
   acq_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 run_live_state[BIT_ACQUISITION_DONE] == $past(acquisition_done))
      else $error("acquisition condition wrong");
   volt_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 fault_live_state[BIT_VOLTAGE_FAULT] == $past(|voltage_fault))
      else $error("voltage fault condition wrong");
   oc_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 fault_live_state[BIT_OVERCURRENT_TRIP] == $past(|overcurrent_trip))
      else $error("overcurrent condition wrong");
   thermal_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 fault_live_state[BIT_THERMAL_TRIP] == $past(|thermal_trip))
      else $error("thermal condition wrong");
   limit_live_a: assert property (@(posedge clk) disable iff (srst)
      ##1 fault_live_state[BIT_CURRENT_LIMIT_ACTIVE] == $past(|current_limit_active))
      else $error("current limit condition wrong");
   reset_value_a: assert property (@(posedge clk)
      srst |=> run_event_mask == MASK_RESET && fault_event_mask == MASK_RESET && run_event_latch == EVENT_RESET
      && fault_event_latch == EVENT_RESET && !reg_rvalid && !run_summary && status_byte == 8'h00)
      else $error("reset values wrong");

   run_read_c: cover property (@(posedge clk) disable iff (srst)
      run_event_latch != '0 ##1 reg_read && reg_select == SEL_RUN_EVENT);
   fault_sum_c: cover property (@(posedge clk) disable iff (srst) $rose(fault_summary));
   phase_read_c: cover property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_PHASE_EVENT && phase_select == 2'h2 && phase_event[2] != '0);
   set_wins_c: cover property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_FAULT_EVENT && fault_live_state != '0);
   bad_phase_c: cover property (@(posedge clk) disable iff (srst)
      reg_read && reg_select == SEL_PHASE_MASK && phase_select == 2'h3);

endmodule
`default_nettype wire

// ---- test/status_event_summary_tb_top.sv ----
// Self-checking bench for the status event summary block, read data checked by a scoreboard queue.
// Assumes status_event_pkg and status_event_summary from hw/ are compiled first.
`timescale 1ns/1ns
`default_nettype none
module status_event_summary_tb_top;
   import status_event_pkg::*;
   logic               clk;
   logic               srst;
   logic [2:0]         op;
   logic [PHASE_N-1:0] src [5];
   logic [PHASE_W-1:0] phase_select;
   logic [SEL_W-1:0]   reg_select;
   logic               reg_read;
   logic               reg_write;
   logic [REG_W-1:0]   reg_wdata;
   logic [REG_W-1:0]   reg_rdata;
   logic               reg_rvalid;
   logic               run_summary;
   logic               fault_summary;
   logic [7:0]         status_byte;
   logic [15:0]        expq [$];
   logic [15:0]        r;
   logic [15:0]        w;
   int                 errors;
   int                 n_compared;
   int                 seed;
   int                 k;
   int                 i;
   int                 p;
   int                 run_pos [3]   = '{BIT_TRIM_DONE, BIT_STEP_SEQUENCE_DONE, BIT_ACQUISITION_DONE};
   int                 fault_pos [5] = '{BIT_VOLTAGE_FAULT, BIT_OVERCURRENT_TRIP, BIT_THERMAL_TRIP,
                                         BIT_REMOTE_INHIBIT, BIT_CURRENT_LIMIT_ACTIVE};

   status_event_summary dut (
      .clk(clk), .srst(srst), .trim_done(op[0]), .step_sequence_done(op[1]), .acquisition_done(op[2]),
      .voltage_fault(src[0]), .overcurrent_trip(src[1]), .thermal_trip(src[2]), .remote_inhibit(src[3]),
      .current_limit_active(src[4]), .phase_select(phase_select), .reg_select(reg_select),
      .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .run_summary(run_summary), .fault_summary(fault_summary),
      .status_byte(status_byte));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic complete_run;
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_word(logic [15:0] got, logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: read data %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_level(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: summary %h, expected %h", $time, got, exp);
      end
   endtask

   // Strobes are lowered here so back-to-back accesses never toggle one in a single step
   task automatic cyc(int n);
      reg_read = 1'b0;
      reg_write = 1'b0;
      repeat (n) @(negedge clk);
   endtask

   task automatic rd(logic [3:0] sel, logic [15:0] exp);
      reg_write = 1'b0;
      reg_select = sel;
      reg_read = 1'b1;
      expq.push_back(exp);
      @(negedge clk);
   endtask

   task automatic wr(logic [3:0] sel, logic [15:0] d);
      reg_read = 1'b0;
      reg_select = sel;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
   endtask

   // Summaries together with the status byte, which carries the fault summary only
   task automatic chk_sum(logic run_exp, logic fault_exp);
      chk_level({7'h00, run_summary}, {7'h00, run_exp});
      chk_level({7'h00, fault_summary}, {7'h00, fault_exp});
      chk_level(status_byte, {4'h0, fault_exp, 3'h0});
   endtask

   // Scoreboard: each answered read takes the oldest expectation
   always @(negedge clk)
      if (reg_rvalid === 1'b1)
      begin
         if (expq.size() == 0)
            chk_word(reg_rdata, 16'hDEAD);
         else
            chk_word(reg_rdata, expq.pop_front());
      end

   initial
   begin
      #(20000 * 50);
      errors++;
      complete_run();
   end

   initial
   begin
      seed = 32'h4B7A81E7;
      errors = 0;
      n_compared = 0;
      srst = 1'b1;
      op = 3'h0;
      foreach (src[j]) src[j] = '0;
      phase_select = '0;
      reg_select = '0;
      reg_read = 1'b0;
      reg_write = 1'b0;
      reg_wdata = '0;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      rd(SEL_RUN_MASK, MASK_RESET);
      rd(SEL_FAULT_MASK, MASK_RESET);
      rd(SEL_RUN_EVENT, EVENT_RESET);
      r = 16'($random(seed));
      wr(SEL_RUN_MASK, r);
      rd(SEL_RUN_MASK, r & RUN_USED_MASK);
      r = 16'($random(seed));
      wr(SEL_FAULT_MASK, r);
      rd(SEL_FAULT_MASK, r & FAULT_USED_MASK);
      phase_select = 2'h1;
      wr(SEL_PHASE_MASK, r);
      rd(SEL_PHASE_MASK, r & FAULT_USED_MASK);
      wr(SEL_PHASE_MASK, 16'h0000);
      phase_select = 2'h3;
      wr(SEL_PHASE_MASK, 16'hFFFF);
      rd(SEL_PHASE_MASK, 16'h0000);
      wr(SEL_RUN_EVENT, 16'hFFFF);
      wr(SEL_RUN_LIVE, 16'hFFFF);
      rd(SEL_RUN_EVENT, 16'h0000);
      rd(SEL_RUN_LIVE, 16'h0000);
      for (i = 9; i < 16; i++)
         rd(i[3:0], 16'h0000);
      wr(SEL_FAULT_MASK, FAULT_USED_MASK);
      // Operation sources, once enabled and once masked off
      for (k = 0; k < 2; k++)
      begin
         wr(SEL_RUN_MASK, (k == 0) ? 16'hFFFF : 16'h0000);
         for (i = 0; i < 3; i++)
         begin
            w = 16'h0001 << run_pos[i];
            op[i] = 1'b1;
            cyc(3);
            rd(SEL_RUN_LIVE, w);
            op[i] = 1'b0;
            cyc(3);
            chk_sum(k == 0, 1'b0);
            rd(SEL_RUN_LIVE, 16'h0000);
            rd(SEL_RUN_EVENT, w);
            rd(SEL_RUN_EVENT, 16'h0000);
            cyc(3);
            chk_sum(1'b0, 1'b0);
         end
      end
      // Fault sources on every phase
      for (i = 0; i < 5; i++)
         for (p = 0; p < PHASE_N; p++)
         begin
            w = 16'h0001 << fault_pos[i];
            src[i][p] = 1'b1;
            cyc(3);
            rd(SEL_FAULT_LIVE, w);
            phase_select = p[1:0];
            rd(SEL_PHASE_LIVE, w);
            src[i][p] = 1'b0;
            cyc(3);
            chk_sum(1'b0, 1'b1);
            phase_select = 2'((p + 1) % PHASE_N);
            rd(SEL_PHASE_EVENT, 16'h0000);
            phase_select = p[1:0];
            rd(SEL_PHASE_EVENT, w);
            rd(SEL_FAULT_EVENT, w);
            rd(SEL_FAULT_EVENT, 16'h0000);
            cyc(3);
            chk_sum(1'b0, 1'b0);
         end
      // New event landing on the same edge as the clearing read
      op[0] = 1'b1;
      cyc(1);
      rd(SEL_RUN_EVENT, 16'h0000);
      op[0] = 1'b0;
      cyc(3);
      rd(SEL_RUN_EVENT, 16'h0001);
      // Same race on the questionable group, with the source still high at the read
      src[2][1] = 1'b1;
      cyc(1);
      rd(SEL_FAULT_EVENT, 16'h0000);
      src[2][1] = 1'b0;
      cyc(3);
      rd(SEL_FAULT_EVENT, 16'h0001 << BIT_THERMAL_TRIP);
      cyc(4);
      chk_word({15'h0000, expq.size() == 0}, 16'h0001);
      complete_run();
   end
endmodule
`default_nettype wire
